// ---- src/lcdcd_device.sv ----
// lcd driver command decoder, device end
`timescale 1ns/1ps
module lcdcd_device #(
    parameter int OTP_CYCLES  = lcdcd_pkg::OTP_CYCLES,
    parameter int INT_OSC_DIV = lcdcd_pkg::INT_OSC_DIV
) (
    input  wire logic           clk_sys,
    input  wire logic           resetn,
    lcdcd_if.device             link,
    output lcdcd_pkg::lcdcd_cfg_t cfg,
    output logic                ramWrValid,
    output logic [7:0]          ramWrData,
    output logic [5:0]          ramWrAddr,
    output logic                frameTick,
    output logic                outputsGrounded,
    output logic                intOscRunning,
    output logic                initBusy
);
    typedef enum logic [2:0] {
        LCDCD_RUN  = 3'h1,
        LCDCD_INIT = 3'h2
    } lcdcd_state_t;

    localparam logic [7:0] OTP_LOAD  = 8'(OTP_CYCLES);
    localparam logic [7:0] INIT_LOAD = 8'(lcdcd_pkg::INIT_CYCLES - 1);
    localparam logic [7:0] OSC_LAST  = 8'(INT_OSC_DIV - 1);
    localparam logic [7:0] FRAME_BASE = 8'(lcdcd_pkg::FRAME_LEN_BASE);

    lcdcd_state_t          state_q, state_d;
    lcdcd_pkg::lcdcd_cfg_t cfg_q, cfg_d;
    logic [7:0] initCnt_q, initCnt_d;
    logic [7:0] otpCnt_q, otpCnt_d;
    logic [5:0] ptr_q, ptr_d;
    logic       wrValid_q, wrValid_d;
    logic [7:0] wrData_q, wrData_d;
    logic [5:0] wrAddr_q, wrAddr_d;
    logic [7:0] oscCnt_q, oscCnt_d;
    logic       oscPhase_q, oscPhase_d;
    logic       oscRun_q, oscRun_d;
    logic       pinPrev_q, pinPrev_d;
    logic [7:0] frameCnt_q, frameCnt_d;
    logic       frameTick_q, frameTick_d;
    logic       pinOe_q, pinOe_d;
    logic       busy_q, busy_d;
    logic       ready_q, ready_d;
    logic       gnd_q, gnd_d;
    logic       initBusy_q, initBusy_d;
    logic       take;
    logic       oscTick;
    logic       selTick;
    logic [7:0] b;

    ////////////////////////////////////////////////////////////////////////
    // command decode
    always_comb begin
        state_d   = state_q;
        cfg_d     = cfg_q;
        initCnt_d = initCnt_q;
        otpCnt_d  = (otpCnt_q != 8'h00) ? otpCnt_q - 8'h01 : otpCnt_q;
        ptr_d     = ptr_q;
        wrValid_d = 1'b0;
        wrData_d  = wrData_q;
        wrAddr_d  = wrAddr_q;
        b         = link.cmdByte;
        take      = link.cmdValid & ready_q;
        case (state_q)
            LCDCD_RUN: begin
                if (take && link.cmdSelect) begin
                    // whole byte goes to display memory, pointer advances
                    wrValid_d = 1'b1;
                    wrData_d  = b;
                    wrAddr_d  = ptr_q;
                    ptr_d     = ptr_q + 6'h01;
                end else if (take) begin
                    // overlapping codes: fixed bytes first, then narrow prefixes
                    if (b == lcdcd_pkg::OP_INIT) begin
                        cfg_d     = lcdcd_pkg::CFG_RESET;
                        ptr_d     = 6'h00;
                        initCnt_d = INIT_LOAD;
                        otpCnt_d  = OTP_LOAD;
                        state_d   = LCDCD_INIT;
                    end else if (b == lcdcd_pkg::OP_OTP) begin
                        otpCnt_d = OTP_LOAD;
                    end else if (b[7:2] == lcdcd_pkg::PFX_OSC) begin
                        cfg_d.clockPinOutputEnable   = b[1];
                        cfg_d.oscillatorSourceSelect = b[0];
                    end else if (b[7:2] == lcdcd_pkg::PFX_PUMP) begin
                        cfg_d.chargePumpEnable     = b[1];
                        cfg_d.pumpMultiplierSelect = b[0];
                    end else if (b[7:2] == lcdcd_pkg::PFX_TEMP) begin
                        cfg_d.temperatureCompensationEnable = b[1];
                        cfg_d.temperatureMeasurementEnable  = b[0];
                    end else if (b[7:2] == lcdcd_pkg::PFX_BIAS) begin
                        cfg_d.biasMode = b[1:0];
                    end else if (b[7:2] == lcdcd_pkg::PFX_BANK) begin
                        cfg_d.inputBankChoice  = b[1];
                        cfg_d.outputBankChoice = b[0];
                    end else if (b[7:2] == lcdcd_pkg::PFX_INV) begin
                        cfg_d.frameInversionBit = b[1]; // bit 0 has no function
                    end else if (b[7:1] == lcdcd_pkg::PFX_FILT) begin
                        cfg_d.temperatureFilterEnable = b[0];
                    end else if (b[7:1] == lcdcd_pkg::PFX_DISP) begin
                        cfg_d.displayEnable = b[0];
                    end else if (b[7:3] == lcdcd_pkg::PFX_SLA) begin
                        cfg_d.regionACoefficient = b[2:0];
                    end else if (b[7:3] == lcdcd_pkg::PFX_SLB) begin
                        cfg_d.regionBCoefficient = b[2:0];
                    end else if (b[7:3] == lcdcd_pkg::PFX_SLC) begin
                        cfg_d.regionCCoefficient = b[2:0];
                    end else if (b[7:3] == lcdcd_pkg::PFX_SLD) begin
                        cfg_d.regionDCoefficient = b[2:0];
                    end else if (b[7:3] == lcdcd_pkg::PFX_MUX) begin
                        cfg_d.muxMode = b[2:0];
                    end else if (b[7:4] == lcdcd_pkg::PFX_VPR_HI) begin
                        cfg_d.lcdVoltageTarget[7:4] = b[3:0];
                    end else if (b[7:4] == lcdcd_pkg::PFX_VPR_LO) begin
                        cfg_d.lcdVoltageTarget[3:0] = b[3:0];
                    end else if (b[7:5] == lcdcd_pkg::PFX_FRAME) begin
                        cfg_d.frameRate = b[4:0];
                    end else if (b[7:6] == lcdcd_pkg::PFX_PTR) begin
                        ptr_d = b[5:0];
                    end
                end
            end
            LCDCD_INIT: begin
                // link only pauses for the reset window, no re-init needed
                if (initCnt_q == 8'h00) begin
                    state_d = LCDCD_RUN;
                end else begin
                    initCnt_d = initCnt_q - 8'h01;
                end
            end
            default: begin
                state_d = LCDCD_RUN;
            end
        endcase
        ready_d = (state_d == LCDCD_RUN);
        busy_d  = (otpCnt_d != 8'h00);
        // registered copies so the ports come straight from flip-flops
        gnd_d      = ~cfg_d.displayEnable;
        initBusy_d = ~ready_d;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q   <= LCDCD_RUN;
            cfg_q     <= lcdcd_pkg::CFG_RESET;
            initCnt_q <= 8'h00;
            otpCnt_q  <= OTP_LOAD; // reload after every reset
            ptr_q     <= 6'h00;
            wrValid_q <= 1'b0;
            wrData_q  <= 8'h00;
            wrAddr_q  <= 6'h00;
            ready_q   <= 1'b0;
            busy_q    <= 1'b1;
            gnd_q     <= 1'b1;
            initBusy_q <= 1'b1;
        end else begin
            state_q   <= state_d;
            cfg_q     <= cfg_d;
            initCnt_q <= initCnt_d;
            otpCnt_q  <= otpCnt_d;
            ptr_q     <= ptr_d;
            wrValid_q <= wrValid_d;
            wrData_q  <= wrData_d;
            wrAddr_q  <= wrAddr_d;
            ready_q   <= ready_d;
            busy_q    <= busy_d;
            gnd_q     <= gnd_d;
            initBusy_q <= initBusy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clocking: internal oscillator, clock pin, frame timing
    always_comb begin
        // oscillator needed for internal timing or for the pump
        oscRun_d   = ~cfg_q.oscillatorSourceSelect | cfg_q.chargePumpEnable;
        oscTick    = oscRun_q && (oscCnt_q == OSC_LAST);
        oscCnt_d   = !oscRun_q ? 8'h00 : (oscTick ? 8'h00 : oscCnt_q + 8'h01);
        oscPhase_d = oscTick ? ~oscPhase_q : oscPhase_q;
        pinPrev_d  = link.clkPinLevel;
        // external source counts rising pin edges instead
        selTick    = cfg_q.oscillatorSourceSelect ? (link.clkPinLevel & ~pinPrev_q)
                                                  : oscTick;
        frameTick_d = 1'b0;
        frameCnt_d  = frameCnt_q;
        if (selTick) begin
            // higher setting gives shorter frame
            if (frameCnt_q >= FRAME_BASE - {3'h0, cfg_q.frameRate}) begin
                frameCnt_d  = 8'h00;
                frameTick_d = 1'b1;
            end else begin
                frameCnt_d = frameCnt_q + 8'h01;
            end
        end
        // only drive own clock; never fight an external source
        pinOe_d = cfg_q.clockPinOutputEnable & ~cfg_q.oscillatorSourceSelect;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            oscCnt_q    <= 8'h00;
            oscPhase_q  <= 1'b0;
            oscRun_q    <= 1'b0;
            pinPrev_q   <= 1'b0;
            frameCnt_q  <= 8'h00;
            frameTick_q <= 1'b0;
            pinOe_q     <= 1'b0; // high impedance from power-on
        end else begin
            oscCnt_q    <= oscCnt_d;
            oscPhase_q  <= oscPhase_d;
            oscRun_q    <= oscRun_d;
            pinPrev_q   <= pinPrev_d;
            frameCnt_q  <= frameCnt_d;
            frameTick_q <= frameTick_d;
            pinOe_q     <= pinOe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign cfg                  = cfg_q;
    assign ramWrValid           = wrValid_q;
    assign ramWrData            = wrData_q;
    assign ramWrAddr            = wrAddr_q;
    assign frameTick            = frameTick_q;
    assign outputsGrounded      = gnd_q;
    assign intOscRunning        = oscRun_q;
    assign initBusy             = initBusy_q;
    assign link.cmdReady        = ready_q;
    assign link.calibrationBusy = busy_q;
    assign link.displayOn       = cfg_q.displayEnable;
    assign link.clkPinDevOut    = oscPhase_q;
    assign link.clkPinDevOe     = pinOe_q;
endmodule

// ---- src/lcdcd_pkg.sv ----
// shared constants and types of the lcd command decoder
package lcdcd_pkg;
    // opcodes and opcode prefixes
    localparam logic [7:0] OP_INIT      = 8'h3A;
    localparam logic [7:0] OP_OTP       = 8'hD0;
    localparam logic [5:0] PFX_OSC      = 6'h33;
    localparam logic [5:0] PFX_PUMP     = 6'h30;
    localparam logic [5:0] PFX_TEMP     = 6'h32;
    localparam logic [5:0] PFX_BIAS     = 6'h31;
    localparam logic [5:0] PFX_BANK     = 6'h02;
    localparam logic [5:0] PFX_INV      = 6'h35;
    localparam logic [6:0] PFX_FILT     = 7'h69;
    localparam logic [6:0] PFX_DISP     = 7'h1C;
    localparam logic [4:0] PFX_SLA      = 5'h03;
    localparam logic [4:0] PFX_SLB      = 5'h04;
    localparam logic [4:0] PFX_SLC      = 5'h05;
    localparam logic [4:0] PFX_SLD      = 5'h06;
    localparam logic [4:0] PFX_MUX      = 5'h00;
    localparam logic [3:0] PFX_VPR_HI   = 4'h4;
    localparam logic [3:0] PFX_VPR_LO   = 4'h5;
    localparam logic [2:0] PFX_FRAME    = 3'h1;
    localparam logic [1:0] PFX_PTR      = 2'h2;

    // settings held by the decoder
    typedef struct packed {
        logic       clockPinOutputEnable;
        logic       oscillatorSourceSelect;
        logic       chargePumpEnable;
        logic       pumpMultiplierSelect;
        logic       temperatureCompensationEnable;
        logic       temperatureMeasurementEnable;
        logic [2:0] regionACoefficient;
        logic [2:0] regionBCoefficient;
        logic [2:0] regionCCoefficient;
        logic [2:0] regionDCoefficient;
        logic [7:0] lcdVoltageTarget;
        logic       displayEnable;
        logic [2:0] muxMode;
        logic [1:0] biasMode;
        logic [4:0] frameRate;
        logic       inputBankChoice;
        logic       outputBankChoice;
        logic       frameInversionBit;
        logic       temperatureFilterEnable;
    } lcdcd_cfg_t;

    localparam lcdcd_cfg_t CFG_RESET = '{
        temperatureCompensationEnable: 1'b1,
        temperatureMeasurementEnable:  1'b1,
        default:                       '0
    };

    // timing
    localparam int SYS_PERIOD_NS  = 4;
    localparam int INIT_RESET_NS  = 100;
    // longest time: round down
    localparam int INIT_CYCLES    = INIT_RESET_NS / SYS_PERIOD_NS;
    localparam int OTP_CYCLES     = 16;
    localparam int INT_OSC_DIV    = 8;
    localparam int FRAME_LEN_BASE = 64;
    localparam int EXT_CLK_DIV    = 6;
endpackage

// ---- src/lcdcd_if.sv ----
// link between host controller and lcd command decoder
`timescale 1ns/1ps
interface lcdcd_if;
    logic       cmdValid;
    logic       cmdSelect;
    logic [7:0] cmdByte;
    logic       cmdReady;
    logic       calibrationBusy;
    logic       displayOn;
    logic       clkPinDevOut;
    logic       clkPinDevOe;
    logic       clkPinHostOut;
    logic       clkPinHostOe;
    logic       clkPinLevel;

    // undriven pin reads low
    assign clkPinLevel = clkPinDevOe ? clkPinDevOut : (clkPinHostOe & clkPinHostOut);

    modport device (
        input  cmdValid, cmdSelect, cmdByte, clkPinLevel,
        output cmdReady, calibrationBusy, displayOn, clkPinDevOut, clkPinDevOe
    );
    modport host (
        output cmdValid, cmdSelect, cmdByte, clkPinHostOut, clkPinHostOe,
        input  cmdReady, calibrationBusy, displayOn, clkPinLevel
    );
endinterface

// ---- src/lcdcd_host.sv ----
// host controller end of the lcd command link
`timescale 1ns/1ps
module lcdcd_host #(
    parameter int EXT_CLK_DIV = lcdcd_pkg::EXT_CLK_DIV
) (
    input  wire logic  clk_sys,
    input  wire logic  resetn,
    lcdcd_if.host      link,
    input  wire logic  reqValid,
    input  wire logic  reqSelect,
    input  wire logic [7:0] reqByte,
    output logic       reqReady,
    output logic       reqRejected,
    input  wire logic  extClockRequest,
    input  wire logic  powerDownRequest,
    output logic       powerDown
);
    typedef enum logic [1:0] {
        LCDCD_IDLE = 2'h1,
        LCDCD_HOLD = 2'h2
    } lcdcd_hstate_t;

    localparam logic [7:0] DIV_LAST = 8'(EXT_CLK_DIV - 1);

    lcdcd_hstate_t state_q, state_d;
    logic       valid_q, valid_d;
    logic       sel_q, sel_d;
    logic [7:0] byte_q, byte_d;
    logic       ready_q, ready_d;
    logic       rej_q, rej_d;
    logic       run_q, run_d;
    logic [7:0] div_q, div_d;
    logic       clk_q, clk_d;
    logic       pd_q, pd_d;
    logic       legal;

    // only listed opcode patterns leave the host
    always_comb begin
        legal = (reqByte == lcdcd_pkg::OP_INIT) || (reqByte == lcdcd_pkg::OP_OTP)
             || (reqByte[7:2] == lcdcd_pkg::PFX_OSC) || (reqByte[7:2] == lcdcd_pkg::PFX_PUMP)
             || (reqByte[7:2] == lcdcd_pkg::PFX_TEMP) || (reqByte[7:2] == lcdcd_pkg::PFX_BIAS)
             || (reqByte[7:2] == lcdcd_pkg::PFX_BANK)
             || (reqByte[7:2] == lcdcd_pkg::PFX_INV && !reqByte[0])
             || (reqByte[7:1] == lcdcd_pkg::PFX_FILT) || (reqByte[7:1] == lcdcd_pkg::PFX_DISP)
             || (reqByte[7:3] >= lcdcd_pkg::PFX_SLA && reqByte[7:3] <= lcdcd_pkg::PFX_SLD)
             || (reqByte[7:3] == lcdcd_pkg::PFX_MUX)
             || (reqByte[7:4] == lcdcd_pkg::PFX_VPR_HI) || (reqByte[7:4] == lcdcd_pkg::PFX_VPR_LO)
             || (reqByte[7:5] == lcdcd_pkg::PFX_FRAME) || (reqByte[7:6] == lcdcd_pkg::PFX_PTR);
    end

    ////////////////////////////////////////////////////////////////////////
    // command issue
    always_comb begin
        state_d = state_q;
        valid_d = valid_q;
        sel_d   = sel_q;
        byte_d  = byte_q;
        rej_d   = 1'b0;
        case (state_q)
            LCDCD_IDLE: begin
                if (reqValid && ready_q) begin
                    if (!reqSelect && !legal) begin
                        rej_d = 1'b1;
                    end else begin
                        valid_d = 1'b1;
                        sel_d   = reqSelect;
                        byte_d  = reqByte;
                        state_d = LCDCD_HOLD;
                    end
                end
            end
            LCDCD_HOLD: begin
                if (link.cmdReady) begin
                    valid_d = 1'b0;
                    state_d = LCDCD_IDLE;
                end
            end
            default: begin
                valid_d = 1'b0;
                state_d = LCDCD_IDLE;
            end
        endcase
        ready_d = (state_d == LCDCD_IDLE);
        // no power-down entry while calibration reloads
        pd_d = powerDownRequest & (pd_q | ~link.calibrationBusy);
        // clock stops only once the display is off
        run_d = extClockRequest | (run_q & link.displayOn);
        div_d = (!run_q || div_q == DIV_LAST) ? 8'h00 : div_q + 8'h01;
        clk_d = (run_q && div_q == DIV_LAST) ? ~clk_q : (clk_q & run_q);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= LCDCD_IDLE;
            valid_q <= 1'b0;
            sel_q   <= 1'b0;
            byte_q  <= 8'h00;
            ready_q <= 1'b0;
            rej_q   <= 1'b0;
            run_q   <= 1'b0;
            div_q   <= 8'h00;
            clk_q   <= 1'b0;
            pd_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            valid_q <= valid_d;
            sel_q   <= sel_d;
            byte_q  <= byte_d;
            ready_q <= ready_d;
            rej_q   <= rej_d;
            run_q   <= run_d;
            div_q   <= div_d;
            clk_q   <= clk_d;
            pd_q    <= pd_d;
        end
    end

    assign reqReady           = ready_q;
    assign reqRejected        = rej_q;
    assign powerDown          = pd_q;
    assign link.cmdValid      = valid_q;
    assign link.cmdSelect     = sel_q;
    assign link.cmdByte       = byte_q;
    assign link.clkPinHostOut = clk_q;
    assign link.clkPinHostOe  = run_q;
endmodule

// ---- testbench/lcdcd_properties.sv ----
// concurrent checks on the lcd command link
`timescale 1ns/1ps
module lcdcd_properties #(
    parameter int OTP_CYCLES  = lcdcd_pkg::OTP_CYCLES,
    parameter int INT_OSC_DIV = lcdcd_pkg::INT_OSC_DIV
) (
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       cmdValid,
    input wire logic       cmdSelect,
    input wire logic [7:0] cmdByte,
    input wire logic       cmdReady,
    input wire logic       calibrationBusy,
    input wire logic       displayOn,
    input wire logic       clkPinDevOut,
    input wire logic       clkPinDevOe,
    input wire logic       clkPinHostOut,
    input wire logic       clkPinHostOe
);
    // slack covers the cycle of the take itself
    localparam int CAL_MAX = OTP_CYCLES + 4;
    localparam int TOG_MAX = 2 * INT_OSC_DIV + 1;
    wire logic take = cmdValid && cmdReady && !cmdSelect;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////
    a_init_ready_gap: assert property (take && cmdByte == lcdcd_pkg::OP_INIT
        |-> ##25 !cmdReady ##1 cmdReady) else $error("ready gap after init wrong");
    a_init_defaults: assert property (take && cmdByte == lcdcd_pkg::OP_INIT
        |=> !displayOn ##1 !clkPinDevOe) else $error("defaults not restored");
    a_cal_start: assert property (take && (cmdByte == lcdcd_pkg::OP_INIT
        || cmdByte == lcdcd_pkg::OP_OTP) |=> calibrationBusy) else $error("no reload");
    a_cal_bounded: assert property (calibrationBusy
        |-> ##[1:CAL_MAX] !calibrationBusy) else $error("reload too long");
    a_display_set: assert property (take && cmdByte[7:1] == lcdcd_pkg::PFX_DISP
        |=> displayOn == $past(cmdByte[0])) else $error("display enable wrong");
    a_osc_pin_drive: assert property (take && cmdByte[7:2] == lcdcd_pkg::PFX_OSC
        |-> ##2 clkPinDevOe == ($past(cmdByte[1], 2) && !$past(cmdByte[0], 2)))
        else $error("clock pin drive wrong");
    a_pin_toggles: assert property (clkPinDevOe
        |-> ##[1:TOG_MAX] ($changed(clkPinDevOut) || !clkPinDevOe)) else $error("pin idle");
    a_hold_offer: assert property (cmdValid && !cmdReady
        |=> cmdValid && $stable(cmdByte) && $stable(cmdSelect)) else $error("offer dropped");
    a_host_clk_runs: assert property (clkPinHostOe && displayOn
        |=> clkPinHostOe) else $error("external clock stopped");
    c_init: cover property (take && cmdByte == lcdcd_pkg::OP_INIT);
    c_pin_out: cover property (clkPinDevOe && clkPinDevOut);
    c_host_clk: cover property (clkPinHostOe && clkPinHostOut);
    c_ram: cover property (cmdValid && cmdReady && cmdSelect);
endmodule

// ---- testbench/tb_lcd_driver_command_decoder.sv ----
// self-checking bench joining host and device ends
`timescale 1ns/1ps
module tb_lcd_driver_command_decoder;
    localparam int EXT_DIV = 2;
    logic                  clk_sys = 1'b0;
    logic                  resetn = 1'b0;
    logic                  reqValid = 1'b0;
    logic                  reqSelect = 1'b0;
    logic [7:0]            reqByte = 8'h00;
    logic                  extReq = 1'b0;
    logic                  pdReq = 1'b0;
    logic                  reqReady, reqRejected, powerDown, rejSeen;
    logic                  ramWrValid, frameTick, outputsGrounded, intOscRunning, initBusy;
    logic [7:0]            ramWrData;
    logic [5:0]            ramWrAddr;
    logic [7:0]            ram [64];
    lcdcd_pkg::lcdcd_cfg_t cfg, exp;
    int                    g;
    int                    n_errors = 0;
    int                    cmp_count = 0;
    always #2 clk_sys = ~clk_sys;
    lcdcd_if lk ();
    lcdcd_device #(.OTP_CYCLES(4), .INT_OSC_DIV(2)) u_lcdcd_device (.clk_sys(clk_sys),
        .resetn(resetn), .link(lk.device), .cfg(cfg), .ramWrValid(ramWrValid),
        .ramWrData(ramWrData), .ramWrAddr(ramWrAddr), .frameTick(frameTick),
        .outputsGrounded(outputsGrounded), .intOscRunning(intOscRunning), .initBusy(initBusy));
    lcdcd_host #(.EXT_CLK_DIV(EXT_DIV)) u_lcdcd_host (.clk_sys(clk_sys), .resetn(resetn),
        .link(lk.host), .reqValid(reqValid), .reqSelect(reqSelect), .reqByte(reqByte),
        .reqReady(reqReady), .reqRejected(reqRejected), .extClockRequest(extReq),
        .powerDownRequest(pdReq), .powerDown(powerDown));
    lcdcd_properties #(.OTP_CYCLES(4), .INT_OSC_DIV(2)) u_lcdcd_properties (
        .clk_sys(clk_sys), .resetn(resetn), .cmdValid(lk.cmdValid), .cmdSelect(lk.cmdSelect),
        .cmdByte(lk.cmdByte), .cmdReady(lk.cmdReady), .calibrationBusy(lk.calibrationBusy),
        .displayOn(lk.displayOn), .clkPinDevOut(lk.clkPinDevOut),
        .clkPinDevOe(lk.clkPinDevOe), .clkPinHostOut(lk.clkPinHostOut),
        .clkPinHostOe(lk.clkPinHostOe));
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        if (ramWrValid === 1'b1)
            ram[ramWrAddr] <= ramWrData;
        if (reqRejected === 1'b1)
            rejSeen <= 1'b1;
    end
    task automatic conclude();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chkVal(input logic [15:0] got, input logic [15:0] want, input string m);
        cmp_count++;
        if (got !== want) begin
            n_errors++;
            $display("Error at %0t: %s got %h want %h", $time, m, got, want);
        end
    endtask
    task automatic chkCfg(input lcdcd_pkg::lcdcd_cfg_t got, input string m);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s cfg %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    // waits for ready under a bound, so a stuck link shows as a mismatch
    task automatic send(input logic s, input logic [7:0] b);
        int n;
        n = 0;
        while (reqReady !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        chkVal(16'(n < 100), 16'h0001, "ready wait");
        reqValid = 1'b1;
        reqSelect = s;
        reqByte = b;
        tick(1);
        reqValid = 1'b0;
        tick(3);
    endtask
    task automatic op(input logic [7:0] b, input string m);
        send(1'b0, b);
        chkCfg(cfg, m);
    endtask
    task automatic frameGap(output int p);
        int n;
        n = 0;
        p = 1;
        while (frameTick !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        tick(1);
        while (frameTick !== 1'b1 && p < 2000) begin
            tick(1);
            p++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        chkVal(16'h0000, 16'h0001, "watchdog");
        conclude();
    end
    initial begin
        rejSeen = 1'b0;
        exp = lcdcd_pkg::CFG_RESET;
        tick(8);
        resetn = 1'b1;
        chkCfg(cfg, "reset");
        chkVal({13'h0000, outputsGrounded, lk.clkPinDevOe, lk.calibrationBusy}, 16'h0005, "rst");
        tick(6);
        chkVal({15'h0000, lk.calibrationBusy}, 16'h0000, "reload end");
        exp.regionACoefficient = 3'h5; op(8'h1D, "coef a");
        exp.regionBCoefficient = 3'h3; op(8'h23, "coef b");
        exp.regionCCoefficient = 3'h6; op(8'h2E, "coef c");
        exp.regionDCoefficient = 3'h7; op(8'h37, "coef d");
        exp.lcdVoltageTarget = 8'hA0; op(8'h4A, "volt hi");
        exp.lcdVoltageTarget = 8'hA5; op(8'h55, "volt lo");
        exp.displayEnable = 1'b1; op(8'h39, "display");
        exp.muxMode = 3'h6; op(8'h06, "mux");
        exp.biasMode = 2'h2; op(8'hC6, "bias");
        exp.frameRate = 5'h1F; op(8'h3F, "frame");
        exp.inputBankChoice = 1'b1; op(8'h0A, "bank");
        exp.frameInversionBit = 1'b1; op(8'hD6, "inversion");
        exp.temperatureFilterEnable = 1'b1; op(8'hD3, "filter");
        exp.temperatureCompensationEnable = 1'b0; op(8'hC9, "temp");
        chkVal({15'h0000, outputsGrounded}, 16'h0000, "display on");
        op(8'hFF, "unlisted");
        chkVal({15'h0000, rejSeen}, 16'h0001, "reject");
        send(1'b0, 8'hBE);
        send(1'b1, 8'hAB);
        send(1'b1, 8'hCD);
        send(1'b1, lcdcd_pkg::OP_INIT);
        chkCfg(cfg, "data not opcode");
        chkVal({ram[62], ram[63]}, 16'hABCD, "ram");
        chkVal({8'h00, ram[0]}, 16'h003A, "ram wrap");
        exp.chargePumpEnable = 1'b1; exp.pumpMultiplierSelect = 1'b1; op(8'hC3, "pump");
        exp.clockPinOutputEnable = 1'b1; op(8'hCE, "clk out");
        chkVal({15'h0000, lk.clkPinDevOe}, 16'h0001, "pin driven");
        exp.oscillatorSourceSelect = 1'b1; op(8'hCF, "ext");
        chkVal({14'h0000, lk.clkPinDevOe, intOscRunning}, 16'h0001, "pump osc");
        exp.chargePumpEnable = 1'b0; exp.pumpMultiplierSelect = 1'b0; op(8'hC0, "pump off");
        chkVal({15'h0000, intOscRunning}, 16'h0000, "osc stopped");
        extReq = 1'b1;
        frameGap(g);
        chkVal(16'(g), 16'(2 * EXT_DIV * (64 - 31 + 1)), "frame gap");
        extReq = 1'b0;
        tick(10);
        chkVal({15'h0000, lk.clkPinHostOe}, 16'h0001, "clock kept");
        exp = lcdcd_pkg::CFG_RESET;
        op(lcdcd_pkg::OP_INIT, "init");
        chkVal({13'h0000, initBusy, lk.calibrationBusy, lk.cmdReady}, 16'h0006, "init win");
        send(1'b0, 8'h39);
        tick(30);
        chkVal({15'h0000, lk.displayOn}, 16'h0001, "after init");
        send(1'b0, lcdcd_pkg::OP_OTP);
        chkVal({15'h0000, lk.calibrationBusy}, 16'h0001, "refresh");
        pdReq = 1'b1;
        repeat (8) begin
            tick(1);
            chkVal({15'h0000, powerDown & lk.calibrationBusy}, 16'h0000, "pd early");
        end
        chkVal({15'h0000, powerDown}, 16'h0001, "pd");
        resetn = 1'b0;
        tick(2);
        exp = lcdcd_pkg::CFG_RESET;
        chkCfg(cfg, "second reset");
        conclude();
    end
endmodule
